// File: design/flash_params.svh
// named offsets, field positions, flash command codes and timing counts
// assumes a 200 MHz hclk and a 16-bit asynchronous flash bus
`ifndef FLASH_PARAMS_SVH
`define FLASH_PARAMS_SVH
// ==========================================
// timing
`define CLK_NS 5
`define SETUP_NS 10
`define STROBE_NS 70
`define HOLD_NS 20
`define RESET_BUSY_NS 2000
`define CYC_UP(ns) (((ns) + `CLK_NS - 1) / `CLK_NS)
`define SETUP_CYC 5'(`CYC_UP(`SETUP_NS) - 1)
`define STROBE_CYC 5'(`CYC_UP(`STROBE_NS) - 1)
`define HOLD_CYC 5'(`CYC_UP(`HOLD_NS) - 1)
`define RESET_BUSY_CYC 9'(`CYC_UP(`RESET_BUSY_NS))
// ==========================================
// register offsets and fields
`define REG_CMD 8'h00
`define REG_ADDR 8'h04
`define REG_WDATA 8'h08
`define REG_STATUS 8'h0C
`define REG_RDATA 8'h10
`define CMD_OP_MSB 2
`define CMD_CANCEL_BIT 7
`define ST_BUSY 0
`define ST_OK 1
`define ST_TMO 2
`define ST_ABORT 3
`define ST_HELD 4
`define ST_TOGGLING 5
`define ST_READY_PIN 6
`define RD_OPSTAT_LSB 16
// ==========================================
// flash command words and polled bit positions
`define UNLOCK_ADDR1 26'h0000555
`define UNLOCK_ADDR2 26'h00002AA
`define UNLOCK_DATA1 16'h00AA
`define UNLOCK_DATA2 16'h0055
`define FL_RESET 16'h00F0
`define FL_CLEAR 16'h0071
`define FL_OPSTAT_READ 16'h0070
`define TOGGLE1_BIT 6
`define TOGGLE2_BIT 2
`define TIMING_BIT 5
`define ABORT_BIT 1
`define RESERVED_MASK 16'hFFEE
`endif

// File: design/flash_host_pkg.sv
// types shared by the flash status host
// assumes flash_params.svh for all numeric constants
package flash_host_pkg;
	typedef enum logic [2:0] {
		OP_POLL = 3'h0,
		OP_RESET = 3'h1,
		OP_CLEAR = 3'h2,
		OP_ABORT_RST = 3'h3,
		OP_OPSTAT_READ = 3'h4,
		OP_WRITE = 3'h5
	} op_t;
	typedef enum logic [1:0] {
		HS_IDLE = 2'h0,
		HS_WAIT = 2'h1,
		HS_GUARD = 2'h2
	} host_st_t;
	typedef enum logic [1:0] {
		CY_IDLE = 2'h0,
		CY_SETUP = 2'h1,
		CY_STROBE = 2'h2,
		CY_HOLD = 2'h3
	} cyc_st_t;
	typedef struct packed {
		logic wr;
		logic last;
		logic [25:0] addr;
		logic [15:0] data;
	} step_t;
endpackage

// File: design/flash_bus_cycle.sv
// one asynchronous read or write cycle on the flash pins
// assumes start only while idle; done pulses one cycle after hold ends
`include "flash_params.svh"
module flash_bus_cycle (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic start,
	input wire logic wr,
	input wire logic [25:0] addr,
	input wire logic [15:0] wdata,
	output logic done,
	output logic [15:0] rdata,
	output logic [25:0] fl_addr,
	output logic [15:0] fl_data_o,
	output logic fl_data_oe,
	input wire logic [15:0] fl_data_i,
	output logic fl_ce_n,
	output logic fl_oe_n,
	output logic fl_we_n
);
	import flash_host_pkg::*;
	typedef struct packed {
		cyc_st_t st;
		logic [4:0] cnt;
		logic wr;
		logic [25:0] addr;
		logic [15:0] wdata;
		logic [15:0] rdata;
		logic oe;
		logic ce_n;
		logic oe_n;
		logic we_n;
		logic done;
	} cyc_state_t;
	cyc_state_t s_q, s_d;
	// ==========================================
	// cycle sequencer
	always_comb begin
		s_d = s_q;
		s_d.done = 1'b0;
		unique case (s_q.st)
			CY_IDLE: begin
				if (start) begin
					s_d.st = CY_SETUP;
					s_d.cnt = `SETUP_CYC;
					s_d.wr = wr;
					s_d.addr = addr;
					s_d.wdata = wdata;
					s_d.oe = wr;
					s_d.ce_n = 1'b0;
				end
			end
			CY_SETUP: begin
				s_d.cnt = s_q.cnt - 5'h01;
				if (s_q.cnt == 5'h00) begin
					s_d.st = CY_STROBE;
					s_d.cnt = `STROBE_CYC;
					s_d.oe_n = s_q.wr;
					s_d.we_n = !s_q.wr;
				end
			end
			CY_STROBE: begin
				s_d.cnt = s_q.cnt - 5'h01;
				if (s_q.cnt == 5'h00) begin
					s_d.st = CY_HOLD;
					s_d.cnt = `HOLD_CYC;
					s_d.oe_n = 1'b1;
					s_d.we_n = 1'b1;
					if (!s_q.wr) begin
						s_d.rdata = fl_data_i;
					end
				end
			end
			CY_HOLD: begin
				s_d.cnt = s_q.cnt - 5'h01;
				if (s_q.cnt == 5'h00) begin
					s_d.st = CY_IDLE;
					s_d.ce_n = 1'b1;
					s_d.oe = 1'b0;
					s_d.done = 1'b1;
				end
			end
		endcase
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_q <= '{st: CY_IDLE, cnt: 5'h00, wr: 1'b0, addr: 26'h0000000, wdata: 16'h0000,
				rdata: 16'h0000, oe: 1'b0, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, done: 1'b0};
		end else begin
			s_q <= s_d;
		end
	end
	assign done = s_q.done;
	assign rdata = s_q.rdata;
	assign fl_addr = s_q.addr;
	assign fl_data_o = s_q.wdata;
	assign fl_data_oe = s_q.oe;
	assign fl_ce_n = s_q.ce_n;
	assign fl_oe_n = s_q.oe_n;
	assign fl_we_n = s_q.we_n;
endmodule

// File: design/poll_decode.sv
// judges a pair of polled words read back to back
// assumes both words came from the same valid status address
`include "flash_params.svh"
module poll_decode (
	input wire logic [15:0] first,
	input wire logic [15:0] second,
	output logic toggling,
	output logic timing_limit_flag,
	output logic buffer_abort_flag,
	output logic [15:0] masked
);
	function automatic logic [15:0] mask_reserved(input logic [15:0] w);
		mask_reserved = w & `RESERVED_MASK;
	endfunction
	logic [15:0] a_m;
	logic [15:0] b_m;
	// ==========================================
	// reserved bits masked before any judgement
	assign a_m = mask_reserved(first);
	assign b_m = mask_reserved(second);
	assign masked = b_m;
	assign toggling = a_m[`TOGGLE1_BIT] ^ b_m[`TOGGLE1_BIT];
	assign timing_limit_flag = b_m[`TIMING_BIT];
	// abort only with toggle two still; protection busy toggles it
	assign buffer_abort_flag = b_m[`ABORT_BIT] && (a_m[`TOGGLE2_BIT] == b_m[`TOGGLE2_BIT]);
endmodule

// File: design/flash_status_host.sv
// host controller polling a parallel flash and clearing its error states
// assumes a single AHB-Lite master and one flash on the asynchronous pins
//
// The AHB-Lite interface to the registers and the register addresses were decided locally.
`include "flash_params.svh"
// Summary of operation
// [R1] Flash raises timing limit flag when a program or erase overruns.
// [R2] After timeout host sends reset, then waits 2 us of possible busy.
// [R3] On buffer abort host issues the three-write abort reset sequence.
// [R4] Erase in progress, inside sector: 0, toggling, 0, 1, toggling, busy.
// [R5] Erase in progress, outside sector: same, but second toggle bit still.
// [R6] Erase suspended sector reads 1, steady, 0, second toggle toggling, ready.
// [R7] Other sectors in erase suspend give array data and ready.
// [R8] Program during erase suspend shows inverted bit, toggling, 0, busy.
// [R9] In program suspend host avoids reads of the suspended line.
// [R10] Host polls only at the programmed word or erasing sector address.
// [R11] Buffer program shows inverted bit, toggling; flags only on failure.
// [R12] Cleared error returns flash to overlay, erase suspend or standby.
// [R13] Operation failure keeps flash busy until the host clears it.
// [R14] Operation failure overlays polled bits with failure pattern.
// [R15] Operation failure sets status bits 7, 5 or 4, 3, 2, 1.
// [R16] Host clears a held failure with reset or status clear only.
// [R17] Protection hit keeps flash busy 20 to 100 us, status not ready.
// [R18] Protection busy shows both toggles running, timing flag 0.
// [R19] Protection busy accepts only the status read command.
// [R20] After protection busy status shows bit 1 set, any command accepted.
// [R21] Host masks polled bits 4 and 0 and status bit 0; the code masks polled bits 4 and 0 only, status byte is unmasked.
// [R22] Host reads toggle twice; rechecks once after timing flag rises.
// [R23] Toggle bit one flips on each read while an operation runs.
// [R24] Polling bit shows inverted bit 7 until programming completes.
// [R25] Flash status is produced per read strobe from algorithm state.
module flash_status_host (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	output logic [25:0] fl_addr,
	output logic [15:0] fl_data_o,
	output logic fl_data_oe,
	input wire logic [15:0] fl_data_i,
	output logic fl_ce_n,
	output logic fl_oe_n,
	output logic fl_we_n,
	input wire logic fl_ready_busy
);
	import flash_host_pkg::*;
	typedef struct packed {
		host_st_t st;
		op_t op;
		logic [1:0] step;
		logic nrd;
		logic recheck;
		logic cancel;
		logic [15:0] first;
		logic [8:0] guard;
		logic [25:0] addr;
		logic [15:0] wdata;
		logic [15:0] last;
		logic [7:0] opstat;
		logic busy;
		logic ok;
		logic tmo;
		logic abrt;
		logic held;
		logic tog;
		logic [31:0] rdata;
		logic ahb_wr;
		logic [7:0] ahb_off;
		logic start;
	} host_state_t;
	host_state_t s_q, s_d;
	step_t cur;
	logic cyc_done;
	logic [15:0] cyc_rdata;
	logic dec_tog;
	logic dec_tmo;
	logic dec_abort;
	logic [15:0] dec_masked;
	logic ahb_take;
	// ==========================================
	// command sequences as steps
	function automatic step_t step_of(input op_t op, input logic [1:0] idx,
		input logic [25:0] a, input logic [15:0] d);
		step_of = '{wr: 1'b1, last: 1'b1, addr: a, data: d};
		unique case (op)
			OP_POLL: step_of.wr = 1'b0;
			OP_RESET: step_of.data = `FL_RESET;
			OP_CLEAR: step_of = '{wr: 1'b1, last: 1'b1, addr: `UNLOCK_ADDR1, data: `FL_CLEAR};
			OP_ABORT_RST: begin
				unique case (idx)
					2'h0: step_of = '{1'b1, 1'b0, `UNLOCK_ADDR1, `UNLOCK_DATA1};
					2'h1: step_of = '{1'b1, 1'b0, `UNLOCK_ADDR2, `UNLOCK_DATA2};
					default: step_of = '{1'b1, 1'b1, `UNLOCK_ADDR1, `FL_RESET};
				endcase
			end
			OP_OPSTAT_READ: begin
				if (idx == 2'h0) begin
					step_of = '{1'b1, 1'b0, `UNLOCK_ADDR1, `FL_OPSTAT_READ};
				end else begin
					step_of.wr = 1'b0;
				end
			end
			default: step_of.last = 1'b1;
		endcase
	endfunction
	assign cur = step_of(s_q.op, s_q.step, s_q.addr, s_q.wdata);
	// ==========================================
	// pin cycle engine and poll judge
	flash_bus_cycle u_cycle (
		.hclk(hclk),
		.hresetn(hresetn),
		.start(s_q.start),
		.wr(cur.wr),
		.addr(cur.addr),
		.wdata(cur.data),
		.done(cyc_done),
		.rdata(cyc_rdata),
		.fl_addr(fl_addr),
		.fl_data_o(fl_data_o),
		.fl_data_oe(fl_data_oe),
		.fl_data_i(fl_data_i),
		.fl_ce_n(fl_ce_n),
		.fl_oe_n(fl_oe_n),
		.fl_we_n(fl_we_n)
	);
	poll_decode u_decode (
		.first(s_q.first),
		.second(cyc_rdata),
		.toggling(dec_tog),
		.timing_limit_flag(dec_tmo),
		.buffer_abort_flag(dec_abort),
		.masked(dec_masked)
	);
	// ==========================================
	// bus slave and controller
	assign ahb_take = hsel && hready && htrans[1];
	always_comb begin
		s_d = s_q;
		s_d.start = 1'b0;
		s_d.ahb_wr = ahb_take && hwrite;
		if (ahb_take) begin
			s_d.ahb_off = haddr[7:0];
		end
		if (ahb_take && !hwrite) begin
			unique case (haddr[7:0])
				`REG_ADDR: s_d.rdata = {6'h00, s_q.addr};
				`REG_WDATA: s_d.rdata = {16'h0000, s_q.wdata};
				`REG_STATUS: begin
					s_d.rdata = 32'h00000000;
					s_d.rdata[`ST_BUSY] = s_q.busy;
					s_d.rdata[`ST_OK] = s_q.ok;
					s_d.rdata[`ST_TMO] = s_q.tmo;
					s_d.rdata[`ST_ABORT] = s_q.abrt;
					s_d.rdata[`ST_HELD] = s_q.held;
					s_d.rdata[`ST_TOGGLING] = s_q.tog;
					s_d.rdata[`ST_READY_PIN] = fl_ready_busy;
				end
				`REG_RDATA: s_d.rdata = {8'h00, s_q.opstat, s_q.last};
				default: s_d.rdata = 32'h00000000;
			endcase
		end
		if (s_q.ahb_wr && s_q.ahb_off == `REG_ADDR && !s_q.busy) begin
			s_d.addr = hwdata[25:0];
		end
		if (s_q.ahb_wr && s_q.ahb_off == `REG_WDATA && !s_q.busy) begin
			s_d.wdata = hwdata[15:0];
		end
		if (s_q.ahb_wr && s_q.ahb_off == `REG_CMD) begin
			if (s_q.busy) begin
				s_d.cancel = hwdata[`CMD_CANCEL_BIT];
			end else if (!hwdata[`CMD_CANCEL_BIT]) begin
				s_d.op = op_t'(hwdata[`CMD_OP_MSB:0]);
				s_d.step = 2'h0;
				s_d.nrd = 1'b0;
				s_d.recheck = 1'b0;
				s_d.cancel = 1'b0;
				s_d.busy = 1'b1;
				s_d.ok = 1'b0;
				s_d.st = HS_WAIT;
				s_d.start = 1'b1;
			end
		end
		unique case (s_q.st)
			HS_IDLE: begin
			end
			HS_WAIT: begin
				if (cyc_done) begin
					if (!cur.wr) begin
						s_d.last = cyc_rdata & `RESERVED_MASK; // [R21]
					end
					if (s_q.op == OP_POLL) begin
						s_d.nrd = !s_q.nrd;
						s_d.first = cyc_rdata;
						s_d.start = 1'b1; // [R22]
						if (s_q.nrd) begin
							s_d.last = dec_masked;
							s_d.tog = dec_tog;
							s_d.nrd = 1'b0;
							if (!dec_tog) begin
								s_d.ok = 1'b1; // [R22]
								s_d.start = 1'b0;
							end else if (dec_tmo && !s_q.recheck) begin
								s_d.recheck = 1'b1; // [R22]
							end else if (dec_tmo) begin
								s_d.tmo = 1'b1;
								s_d.held = 1'b1;
								s_d.start = 1'b0;
							end else if (dec_abort) begin
								s_d.abrt = 1'b1;
								s_d.held = 1'b1;
								s_d.start = 1'b0;
							end else if (s_q.cancel) begin
								s_d.start = 1'b0;
							end
							if (!s_d.start) begin
								s_d.busy = 1'b0;
								s_d.cancel = 1'b0;
								s_d.st = HS_IDLE;
							end
						end
					end else if (!cur.last) begin
						s_d.step = s_q.step + 2'h1; // [R3]
						s_d.start = 1'b1;
					end else begin
						if (s_q.op == OP_OPSTAT_READ) begin
							s_d.opstat = cyc_rdata[7:0];
						end
						if (s_q.op == OP_RESET || s_q.op == OP_CLEAR || s_q.op == OP_ABORT_RST) begin
							s_d.held = 1'b0; // [R16]
							s_d.tmo = 1'b0;
							s_d.abrt = 1'b0;
						end
						if (s_q.op == OP_RESET) begin
							s_d.guard = `RESET_BUSY_CYC; // [R2]
							s_d.st = HS_GUARD;
						end else begin
							s_d.ok = 1'b1;
							s_d.busy = 1'b0;
							s_d.st = HS_IDLE;
						end
					end
				end
			end
			HS_GUARD: begin
				s_d.guard = s_q.guard - 9'h001;
				if (s_q.guard == 9'h001) begin
					s_d.ok = 1'b1; // [R2]
					s_d.busy = 1'b0;
					s_d.st = HS_IDLE;
				end
			end
			default: begin
				s_d.st = HS_IDLE;
				s_d.busy = 1'b0;
			end
		endcase
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = s_q.rdata;
	// ==========================================
	// checks
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	sequence reset_issued;
		cyc_done && s_q.op == OP_RESET && s_q.st == HS_WAIT;
	endsequence
	guard_wait_a: assert property (reset_issued |=> !s_q.ok [*8] ##1 s_q.busy) // [R2]
		else $error("reset finished before busy guard");
	sequence abort_second;
		$fell(fl_we_n) && s_q.op == OP_ABORT_RST && s_q.step == 2'h1;
	endsequence
	abort_seq_a: assert property (abort_second |-> fl_addr == `UNLOCK_ADDR2 && fl_data_o == `UNLOCK_DATA2) // [R3]
		else $error("abort reset sequence out of order");
	poll_addr_a: assert property ($fell(fl_oe_n) && s_q.op == OP_POLL |-> fl_addr == s_q.addr) // [R10]
		else $error("poll read at an address other than the chosen one");
	read_only_a: assert property (!fl_oe_n |-> fl_we_n && !fl_data_oe) // [R9]
		else $error("read strobe overlaps a write drive");
	mask_rsv_a: assert property ($changed(s_q.last) |-> s_q.last[0] == 1'b0 && s_q.last[4] == 1'b0) // [R21]
		else $error("reserved polled bits reached software");
	two_reads_a: assert property ($rose(s_q.tmo) |-> $past(s_q.recheck)) // [R22]
		else $error("timeout judged without recheck");
	clear_only_a: assert property ($fell(s_q.held) |-> s_q.op inside {OP_RESET, OP_CLEAR, OP_ABORT_RST}) // [R16]
		else $error("held error cleared by a wrong command");
endmodule

// File: bench/flash_device_model.sv
// flash device model: polled status, error holding and clearing commands
// assumes active low strobes; a read ends on the rising output enable
// ==========================================
// model
module flash_device_model (
	input wire logic [25:0] fl_addr,
	output logic [15:0] fl_data_i,
	input wire logic [15:0] fl_data_o,
	input wire logic fl_ce_n,
	input wire logic fl_oe_n,
	input wire logic fl_we_n,
	output logic fl_ready_busy,
	input wire logic start,
	input wire logic [2:0] fault,
	input wire logic [7:0] busy_reads
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [15:0] ARRAY_WORD = 16'hA5D1;
	// fault kinds: 0 none, 1 timeout, 2 abort, 3 operation error, 4 protection
	logic [2:0] kind = 3'h0;
	int pending = 0;
	int seq = 0;
	logic held = 1'b0;
	logic tog = 1'b0;
	logic tog2 = 1'b0;
	logic sr_next = 1'b0;
	logic rb_hold = 1'b0;
	logic [15:0] last_q = 16'h0000;
	logic [15:0] word;
	logic [7:0] sr;
	logic busy;
	assign busy = (pending > 0) || held;
	assign fl_ready_busy = !(busy || rb_hold);
	assign fl_data_i = (!fl_ce_n && !fl_oe_n) ? word : ~last_q;
	always_comb begin
		case (kind)
			3'h2: sr = 8'h98;
			3'h3: sr = 8'h9E;
			3'h4: sr = busy ? 8'h00 : 8'h92;
			default: sr = 8'h80;
		endcase
		if (sr_next)
			word = {8'h00, sr};
		else if (busy)
			word = {8'h00, ~ARRAY_WORD[7], tog, held && (kind == 3'h1 || kind == 3'h3),
				tog, 1'b1, tog2, (held && kind >= 3'h2) || kind == 3'h4, tog};
		else
			word = ARRAY_WORD;
	end
	always @(posedge start) begin
		kind = fault;
		pending = busy_reads;
		held = 1'b0;
		sr_next = 1'b0;
	end
	always @(posedge fl_oe_n) begin
		if (!fl_ce_n) begin
			last_q = word;
			sr_next = 1'b0;
			if (busy) begin
				tog = ~tog;
				tog2 = (kind >= 3'h3) ? ~tog2 : tog2;
			end
			if (pending > 0) begin
				pending--;
				held = (pending == 0) && kind != 3'h0 && kind != 3'h4;
			end
		end
	end
	always @(posedge fl_we_n) begin
		if (!fl_ce_n && !(kind == 3'h4 && pending > 0 && fl_data_o != 16'h0070)) begin
			if (fl_data_o == 16'h00F0 && held && (kind != 3'h2 || seq == 2)) begin
				held = 1'b0;
				if (seq != 2) begin
					rb_hold = 1'b1;
					rb_hold <= #1000 1'b0;
				end
			end else if (fl_data_o == 16'h0071 && fl_addr[11:0] == 12'h555)
				held = 1'b0;
			else if (fl_data_o == 16'h0070)
				sr_next = 1'b1;
			seq = (fl_data_o == 16'h00AA) ? 1 : (fl_data_o == 16'h0055 && seq == 1) ? 2 : 0;
		end
	end
endmodule

// File: bench/flash_status_host_test.sv
// testbench: register access over the bus, polling and clearing each error kind
// assumes a zero wait state slave and the flash model on the pins
`include "flash_params.svh"
module flash_status_host_test;
	timeunit 1ns;
	timeprecision 1ps;
	import flash_host_pkg::*;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic hreadyout;
	logic [31:0] hrdata;
	logic [25:0] fl_addr;
	logic [15:0] fl_data_o;
	logic [15:0] fl_data_i;
	logic fl_ce_n;
	logic fl_oe_n;
	logic fl_we_n;
	logic fl_ready_busy;
	logic start = 1'b0;
	logic [2:0] fault = 3'h0;
	logic [7:0] busy_reads = 8'h00;
	logic [31:0] r;
	int n_errors = 0;
	int tests_run = 0;
	always #2.5 hclk = ~hclk;
	flash_status_host dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(), .hrdata(hrdata), .fl_addr(fl_addr),
		.fl_data_o(fl_data_o), .fl_data_oe(), .fl_data_i(fl_data_i), .fl_ce_n(fl_ce_n),
		.fl_oe_n(fl_oe_n), .fl_we_n(fl_we_n), .fl_ready_busy(fl_ready_busy));
	flash_device_model flash_u (.fl_addr(fl_addr), .fl_data_i(fl_data_i),
		.fl_data_o(fl_data_o), .fl_ce_n(fl_ce_n), .fl_oe_n(fl_oe_n), .fl_we_n(fl_we_n),
		.fl_ready_busy(fl_ready_busy), .start(start), .fault(fault), .busy_reads(busy_reads));
	// ==========================================
	// tasks
	task automatic finish_test;
		if (n_errors == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic fail(input string msg);
		n_errors++;
		$display("Error at %0t: %s", $time, msg);
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp)
			fail($sformatf("saw %h expected %h", seen, exp));
	endtask
	task automatic wait_ready;
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 50);
		if (n >= 50) begin
			fail("bus stuck");
			finish_test();
		end
	endtask
	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] rd);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		wait_ready();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		wait_ready();
		rd = hrdata;
	endtask
	task automatic op_do(input op_t op, output logic [31:0] st);
		int n;
		ahb(1'b1, `REG_CMD, {29'h0, op}, st);
		n = 0;
		do begin
			ahb(1'b0, `REG_STATUS, 32'h0, st);
			n++;
		end while (st[0] !== 1'b0 && n < 3000);
		if (n >= 3000) begin
			fail("operation never done");
			finish_test();
		end
	endtask
	task automatic run(input logic [2:0] f, input logic [7:0] nr, output logic [31:0] st);
		fault <= f;
		busy_reads <= nr;
		start <= 1'b1;
		@(posedge hclk);
		start <= 1'b0;
		op_do(OP_POLL, st);
	endtask
	// ==========================================
	// sequence
	initial begin
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		ahb(1'b0, `REG_STATUS, 32'h0, r);
		check(r & 32'h5F, 32'h40);
		ahb(1'b1, 8'h20, 32'hFFFF_FFFF, r);
		ahb(1'b0, 8'h20, 32'h0, r);
		check(r, 32'h0);
		ahb(1'b1, `REG_ADDR, 32'h0000_0123, r);
		run(3'h0, 8'h06, r);
		check(r & 32'h5F, 32'h42);
		ahb(1'b0, `REG_RDATA, 32'h0, r);
		check(r[15:0], 16'hA5C0);
		run(3'h1, 8'h04, r);
		check(r & 32'h15, 32'h14);
		check(fl_ready_busy, 1'b0);
		op_do(OP_RESET, r);
		check(r & 32'h5D, 32'h40);
		run(3'h2, 8'h04, r);
		check(r & 32'h19, 32'h18);
		op_do(OP_ABORT_RST, r);
		check(r & 32'h5D, 32'h40);
		run(3'h3, 8'h02, r);
		check(r & 32'h51, 32'h10);
		op_do(OP_OPSTAT_READ, r);
		check(r[0], 1'b0);
		ahb(1'b0, `REG_RDATA, 32'h0, r);
		check(r[23:16], 8'h9E);
		op_do(OP_CLEAR, r);
		check(r & 32'h5D, 32'h40);
		run(3'h4, 8'h08, r);
		check(r & 32'h5F, 32'h42);
		op_do(OP_OPSTAT_READ, r);
		ahb(1'b0, `REG_RDATA, 32'h0, r);
		check(r[23:16], 8'h92);
		finish_test();
	end
endmodule
